// ---- dsp_timer_consts.svh ----
// constants of the dual-slope pwm timer: offsets, fields, reset values, counts
`ifndef DSP_TIMER_CONSTS_SVH
`define DSP_TIMER_CONSTS_SVH

// apb byte offsets
`define DSP_OFS_CTRL        12'h000
`define DSP_OFS_STATUS      12'h004
`define DSP_OFS_COUNT       12'h008
`define DSP_OFS_CMP_A       12'h00C
`define DSP_OFS_CMP_B       12'h010
`define DSP_OFS_CAPTURE     12'h014

// control register fields
`define DSP_CTRL_MODE_LSB   0
`define DSP_CTRL_ACT_A_LSB  4
`define DSP_CTRL_ACT_B_LSB  6
`define DSP_CTRL_CSEL_LSB   8
`define DSP_CTRL_DIR_A_BIT  11
`define DSP_CTRL_DIR_B_BIT  12
`define DSP_CTRL_RST        13'h0000

// status register bits
`define DSP_ST_OVF_BIT      0
`define DSP_ST_MATCH_A_BIT  1
`define DSP_ST_MATCH_B_BIT  2
`define DSP_ST_CAPT_BIT     3
`define DSP_ST_UP_BIT       4

// waveform mode select codes
`define DSP_MODE_PC8        4'h1
`define DSP_MODE_PC9        4'h2
`define DSP_MODE_PC10       4'h3
`define DSP_MODE_PFC_CAPT   4'h8
`define DSP_MODE_PFC_CMPA   4'h9
`define DSP_MODE_PC_CAPT    4'hA
`define DSP_MODE_PC_CMPA    4'hB

// fixed top values and limits
`define DSP_TOP_8BIT        16'h00FF
`define DSP_TOP_9BIT        16'h01FF
`define DSP_TOP_10BIT       16'h03FF
`define DSP_TOP_MIN         16'h0003
`define DSP_BOTTOM          16'h0000

// output action codes
`define DSP_ACT_OFF         2'h0
`define DSP_ACT_TOGGLE      2'h1
`define DSP_ACT_NONINV      2'h2
`define DSP_ACT_INV         2'h3

// prescaler: tick every N clocks, value is N-1
`define DSP_PRE_DIV1        10'h000
`define DSP_PRE_DIV8        10'h007
`define DSP_PRE_DIV64       10'h03F
`define DSP_PRE_DIV256      10'h0FF
`define DSP_PRE_DIV1024     10'h3FF

`endif

// ---- dsp_pkg.sv ----
// types of the dual-slope pwm timer
package dsp_pkg;
	typedef enum logic {dsp_count_up, dsp_count_down} dsp_dir_t;

	typedef struct packed {
		logic [9:0] div_cnt;
	} dsp_presc_state_t;

	typedef struct packed {
		logic [15:0] cnt;
		dsp_dir_t    dir;
		logic [15:0] ocr_a;
		logic [15:0] ocr_b;
		logic [15:0] buf_a;
		logic [15:0] buf_b;
		logic [15:0] icr;
		logic [12:0] ctrl;
		logic [3:0]  flags;
		logic        out_a;
		logic        out_b;
		logic [31:0] rdata;
	} dsp_timer_state_t;
endpackage

// ---- dsp_tick_if.sv ----
// clock select and timer tick between timer core and prescaler
`timescale 1ns/1ps
interface dsp_tick_if;
	logic [2:0] clock_select;
	logic       timer_tick;
	modport presc (input clock_select, output timer_tick);
	modport timer (output clock_select, input timer_tick);
endinterface

// ---- dsp_prescaler.sv ----
// prescaler making the timer tick enable from the i/o clock
`timescale 1ns/1ps
`include "dsp_timer_consts.svh"
module dsp_prescaler (
	input  wire logic   clk_i,
	input  wire logic   rst_b_i,
	dsp_tick_if.presc   tick_if
);
	dsp_pkg::dsp_presc_state_t s_q;
	dsp_pkg::dsp_presc_state_t s_d;
	logic [9:0]                limit;

	// divide by 1, 8, 64, 256 or 1024; select 0 stops the timer
	always_comb begin
		limit = `DSP_PRE_DIV1;
		unique case (tick_if.clock_select)
			3'h2:    limit = `DSP_PRE_DIV8;
			3'h3:    limit = `DSP_PRE_DIV64;
			3'h4:    limit = `DSP_PRE_DIV256;
			3'h5:    limit = `DSP_PRE_DIV1024;
			default: limit = `DSP_PRE_DIV1;
		endcase
		s_d = s_q;
		if (tick_if.clock_select == 3'h0 || s_q.div_cnt >= limit) begin
			s_d.div_cnt = 10'h000;
		end else begin
			s_d.div_cnt = s_q.div_cnt + 10'h001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// one-cycle enable, never a derived clock
	assign tick_if.timer_tick = (tick_if.clock_select != 3'h0) && (s_q.div_cnt >= limit);
endmodule // dsp_prescaler

// ---- dsp_timer.sv ----
// dual-slope pwm timer core with apb slave and compare outputs
// Operation
// - phase correct: overflow flag on reaching bottom
// - phase correct: top register flag at load
// - fixed top masks compare bits on write
// - compare above top never matches
// - phase correct loads at top; asymmetric
// - action two non-inverted, three inverted
// - up-match clears, down-match sets; inverted opposite
// - pin driven only when direction selects output
// - frequency is clock over 2*N*top
// - bottom compare low, top compare high
// - compare a top with toggle: 50% duty
// - modes 8,9: count bottom-top-bottom
// - top from capture/compare a; held one tick
// - register top resolution 2 to 16 bits; code also takes tops below 0x0003
// - frequency mode: overflow with bottom load
// - frequency mode: top register flag at top
// - bottom load gives symmetric slopes
// - match flag on count equal compare
// - synchronous; tick is only an enable
// - modes 1,2,3,10,11 are phase correct
// - phase correct top fixed or from register
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "dsp_timer_consts.svh"
module dsp_timer (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             wave_out_a_o,
	output logic             wave_out_a_oe_o,
	output logic             wave_out_b_o,
	output logic             wave_out_b_oe_o
);
	dsp_pkg::dsp_timer_state_t s_q;
	dsp_pkg::dsp_timer_state_t s_d;
	dsp_tick_if                tick_if ();

	logic [3:0]  waveform_mode_select;
	logic [1:0]  output_a_action_field;
	logic [1:0]  output_b_action_field;
	logic        pin_direction_bit_a;
	logic        pin_direction_bit_b;
	logic        timer_tick;
	logic        pc_mode;
	logic        pfc_mode;
	logic        dual_mode;
	logic        fixed_top;
	logic        top_is_capt;
	logic        top_is_cmpa;
	logic [15:0] top;
	logic        toggle_ok;
	logic [15:0] cnt_n;
	dsp_pkg::dsp_dir_t dir_n;
	logic        arrive_top;
	logic        arrive_bot;
	logic        load_now;
	logic        slope_up;
	logic [15:0] cmp_a_eff;
	logic [15:0] cmp_b_eff;
	logic        match_a;
	logic        match_b;
	logic [3:0]  flag_set;
	logic [3:0]  flag_clr;
	logic        setup;
	logic        wr;
	logic        mapped;
	logic [15:0] wmask;

	dsp_prescaler u_presc (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.tick_if (tick_if)
	);

	// control fields
	assign waveform_mode_select  = s_q.ctrl[`DSP_CTRL_MODE_LSB +: 4];
	assign output_a_action_field = s_q.ctrl[`DSP_CTRL_ACT_A_LSB +: 2];
	assign output_b_action_field = s_q.ctrl[`DSP_CTRL_ACT_B_LSB +: 2];
	assign pin_direction_bit_a   = s_q.ctrl[`DSP_CTRL_DIR_A_BIT];
	assign pin_direction_bit_b   = s_q.ctrl[`DSP_CTRL_DIR_B_BIT];
	assign tick_if.clock_select  = s_q.ctrl[`DSP_CTRL_CSEL_LSB +: 3];
	assign timer_tick            = tick_if.timer_tick;

	// mode decode; other codes are not dual-slope and hold the counter
	always_comb begin
		pc_mode     = 1'b0;
		pfc_mode    = 1'b0;
		fixed_top   = 1'b0;
		top_is_capt = 1'b0;
		top_is_cmpa = 1'b0;
		top         = s_q.icr;
		unique case (waveform_mode_select)
			`DSP_MODE_PC8: begin
				pc_mode   = 1'b1;
				fixed_top = 1'b1;
				top       = `DSP_TOP_8BIT;
			end
			`DSP_MODE_PC9: begin
				pc_mode   = 1'b1;
				fixed_top = 1'b1;
				top       = `DSP_TOP_9BIT;
			end
			`DSP_MODE_PC10: begin
				pc_mode   = 1'b1;
				fixed_top = 1'b1;
				top       = `DSP_TOP_10BIT;
			end
			`DSP_MODE_PFC_CAPT: begin
				pfc_mode    = 1'b1;
				top_is_capt = 1'b1;
				top         = s_q.icr;
			end
			`DSP_MODE_PFC_CMPA: begin
				pfc_mode    = 1'b1;
				top_is_cmpa = 1'b1;
				top         = s_q.ocr_a;
			end
			`DSP_MODE_PC_CAPT: begin
				pc_mode     = 1'b1;
				top_is_capt = 1'b1;
				top         = s_q.icr;
			end
			`DSP_MODE_PC_CMPA: begin
				pc_mode     = 1'b1;
				top_is_cmpa = 1'b1;
				top         = s_q.ocr_a;
			end
			default: top = s_q.icr;
		endcase
	end
	// register tops span 0x0000 up to 0xFFFF, any 16-bit value is taken
	assign dual_mode = pc_mode | pfc_mode;
	assign toggle_ok = top_is_cmpa;

	// up/down step; top is held for exactly one tick before turning
	always_comb begin
		cnt_n = s_q.cnt;
		dir_n = s_q.dir;
		if (s_q.dir == dsp_pkg::dsp_count_up) begin
			if (s_q.cnt == top) begin
				dir_n = dsp_pkg::dsp_count_down;
				cnt_n = s_q.cnt - 16'h0001;
			end else begin
				cnt_n = s_q.cnt + 16'h0001;
			end
		end else if (s_q.cnt == `DSP_BOTTOM) begin
			dir_n = dsp_pkg::dsp_count_up;
			cnt_n = s_q.cnt + 16'h0001;
		end else begin
			cnt_n = s_q.cnt - 16'h0001;
		end
	end

	// load at top in phase correct, at bottom in frequency mode
	assign arrive_top = timer_tick && dual_mode && s_q.dir == dsp_pkg::dsp_count_up && cnt_n == top;
	assign arrive_bot = timer_tick && dual_mode && s_q.dir == dsp_pkg::dsp_count_down
	                    && cnt_n == `DSP_BOTTOM;
	assign load_now   = pfc_mode ? arrive_bot : arrive_top;
	assign cmp_a_eff  = load_now ? s_q.buf_a : s_q.ocr_a;
	assign cmp_b_eff  = load_now ? s_q.buf_b : s_q.ocr_b;

	// at top the down slope starts, at bottom the up slope, so the extremes stick
	assign slope_up = arrive_bot ? 1'b1 : (arrive_top ? 1'b0 : dir_n == dsp_pkg::dsp_count_up);

	// compare above top is gated off, though a count or top write can leave the counter above top
	assign match_a = timer_tick && dual_mode && cnt_n == cmp_a_eff && cmp_a_eff <= top;
	assign match_b = timer_tick && dual_mode && cnt_n == cmp_b_eff && cmp_b_eff <= top;

	// flag events
	always_comb begin
		flag_set = 4'h0;
		flag_set[`DSP_ST_OVF_BIT]     = arrive_bot;
		flag_set[`DSP_ST_MATCH_A_BIT] = match_a | (arrive_top & top_is_cmpa);
		flag_set[`DSP_ST_MATCH_B_BIT] = match_b;
		flag_set[`DSP_ST_CAPT_BIT]    = arrive_top & top_is_capt;
	end

	// apb decode; zero wait state, read data latched in the setup cycle
	assign setup  = psel_i && !penable_i;
	assign wr     = psel_i && penable_i && pwrite_i;
	assign mapped = paddr_i == `DSP_OFS_CTRL || paddr_i == `DSP_OFS_STATUS
	             || paddr_i == `DSP_OFS_COUNT || paddr_i == `DSP_OFS_CMP_A
	             || paddr_i == `DSP_OFS_CMP_B || paddr_i == `DSP_OFS_CAPTURE;
	assign flag_clr = (wr && paddr_i == `DSP_OFS_STATUS) ? pwdata_i[3:0] : 4'h0;
	// unused high bits vanish in fixed-top modes
	assign wmask = fixed_top ? top : 16'hFFFF;

	// next state of the whole core
	always_comb begin
		s_d = s_q;
		if (timer_tick && dual_mode) begin
			s_d.cnt = cnt_n;
			s_d.dir = dir_n;
		end
		if (load_now) begin
			s_d.ocr_a = s_q.buf_a;
			s_d.ocr_b = s_q.buf_b;
		end
		// output actions on match, set and clear by slope
		if (match_a) begin
			unique case (output_a_action_field)
				`DSP_ACT_NONINV: s_d.out_a = !slope_up;
				`DSP_ACT_INV:    s_d.out_a = slope_up;
				`DSP_ACT_TOGGLE: s_d.out_a = toggle_ok ? !s_q.out_a : s_q.out_a;
				`DSP_ACT_OFF:    s_d.out_a = s_q.out_a;
			endcase
		end
		if (match_b) begin
			unique case (output_b_action_field)
				`DSP_ACT_NONINV: s_d.out_b = !slope_up;
				`DSP_ACT_INV:    s_d.out_b = slope_up;
				`DSP_ACT_TOGGLE: s_d.out_b = s_q.out_b;
				`DSP_ACT_OFF:    s_d.out_b = s_q.out_b;
			endcase
		end
		// a new event beats a clear in the same cycle
		s_d.flags = (s_q.flags & ~flag_clr) | flag_set;
		if (wr) begin
			unique case (paddr_i)
				`DSP_OFS_CTRL:    s_d.ctrl  = pwdata_i[12:0];
				`DSP_OFS_COUNT:   s_d.cnt   = pwdata_i[15:0];
				`DSP_OFS_CMP_A:   s_d.buf_a = pwdata_i[15:0] & wmask;
				`DSP_OFS_CMP_B:   s_d.buf_b = pwdata_i[15:0] & wmask;
				`DSP_OFS_CAPTURE: s_d.icr   = pwdata_i[15:0];
				default:          s_d.ctrl  = s_q.ctrl;
			endcase
		end
		if (setup) begin
			s_d.rdata = 32'h0000_0000;
			unique case (paddr_i)
				`DSP_OFS_CTRL:    s_d.rdata = {19'h0, s_q.ctrl};
				`DSP_OFS_STATUS:  s_d.rdata = {27'h0, s_q.dir == dsp_pkg::dsp_count_up, s_q.flags};
				`DSP_OFS_COUNT:   s_d.rdata = {16'h0, s_q.cnt};
				`DSP_OFS_CMP_A:   s_d.rdata = {16'h0, s_q.buf_a};
				`DSP_OFS_CMP_B:   s_d.rdata = {16'h0, s_q.buf_b};
				`DSP_OFS_CAPTURE: s_d.rdata = {16'h0, s_q.icr};
				default:          s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// single register bank
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q      <= '0;
			s_q.ctrl <= `DSP_CTRL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata_o  = s_q.rdata;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;

	// pin drive needs an action and the direction bit
	assign wave_out_a_o    = s_q.out_a;
	assign wave_out_b_o    = s_q.out_b;
	assign wave_out_a_oe_o = pin_direction_bit_a && (output_a_action_field[1]
	                         || (output_a_action_field == `DSP_ACT_TOGGLE && toggle_ok));
	assign wave_out_b_oe_o = pin_direction_bit_b && output_b_action_field[1];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	chk_ovf_bottom: assert property (
		(timer_tick && dual_mode && s_q.dir == dsp_pkg::dsp_count_down && s_q.cnt == 16'h0001
		 && !wr) |=> s_q.flags[`DSP_ST_OVF_BIT] && s_q.cnt == 16'h0000)
		else $error("overflow flag missing at bottom");
	chk_top_hold: assert property (
		(timer_tick && dual_mode && s_q.dir == dsp_pkg::dsp_count_up && s_q.cnt == top && !wr)
		|=> s_q.dir == dsp_pkg::dsp_count_down && s_q.cnt == $past(s_q.cnt) - 16'h0001)
		else $error("counter did not turn after top");
	chk_pc_load_top: assert property (
		(arrive_top && pc_mode) |=> s_q.ocr_b == $past(s_q.buf_b))
		else $error("phase correct load at top missing");
	chk_pfc_load_bot: assert property (
		(pfc_mode && !load_now && !(wr && paddr_i == `DSP_OFS_CTRL)) |=> $stable(s_q.ocr_b))
		else $error("frequency mode compare changed off bottom");
	chk_mask_fixed: assert property (
		(wr && fixed_top && paddr_i == `DSP_OFS_CMP_A) |=> (s_q.buf_a & ~$past(top)) == 16'h0000)
		else $error("fixed top mask not applied");
	// watches the stored flag, not the match term, so a broken gate shows up here
	chk_match_range: assert property (
		(timer_tick && dual_mode && cmp_b_eff > top && !s_q.flags[`DSP_ST_MATCH_B_BIT])
		|=> !s_q.flags[`DSP_ST_MATCH_B_BIT])
		else $error("match flag above top");
	chk_pin_dir: assert property (
		!pin_direction_bit_a |-> !wave_out_a_oe_o)
		else $error("pin driven without direction bit");
	chk_up_clear: assert property (
		(match_a && output_a_action_field == `DSP_ACT_NONINV && dir_n == dsp_pkg::dsp_count_up
		 && !arrive_top && !wr) |=> !s_q.out_a)
		else $error("non-inverted up match did not clear");
	chk_down_set: assert property (
		(match_a && output_a_action_field == `DSP_ACT_NONINV && dir_n == dsp_pkg::dsp_count_down
		 && !arrive_bot && !wr) |=> s_q.out_a)
		else $error("non-inverted down match did not set");
	chk_toggle_a: assert property (
		(match_a && output_a_action_field == `DSP_ACT_TOGGLE && toggle_ok && !wr)
		|=> s_q.out_a != $past(s_q.out_a))
		else $error("toggle action did not toggle");
	chk_ovf_race: assert property (
		(flag_set[`DSP_ST_OVF_BIT] && flag_clr[`DSP_ST_OVF_BIT]) |=> s_q.flags[`DSP_ST_OVF_BIT])
		else $error("overflow flag lost to a clear");
	chk_flag_top: assert property (
		(arrive_top && top_is_capt && !wr) |=> s_q.flags[`DSP_ST_CAPT_BIT])
		else $error("top register flag missing");

	cov_pc_turn:   cover property (arrive_top && pc_mode ##1 s_q.cnt == top);
	cov_pfc_load:  cover property (arrive_bot && pfc_mode);
	cov_toggle_a:  cover property (match_a && output_a_action_field == `DSP_ACT_TOGGLE && toggle_ok);
	cov_flag_race: cover property (flag_set[`DSP_ST_OVF_BIT] && flag_clr[`DSP_ST_OVF_BIT]);
endmodule // dsp_timer

// ---- dsp_pin_model.sv ----
// port pin model for one compare output, no pull on the line
`timescale 1ns/1ps
module dsp_pin_model (
	input  wire logic clk_i,
	input  wire logic drive_i,
	input  wire logic level_i,
	output logic      pin_o
);
	logic float_q = 1'b0;

	// a released pin wanders, so a stale level can never pass for the output
	always_ff @(posedge clk_i) begin
		float_q <= ~float_q;
	end

	// pin shows the compare output only while its driver is enabled
	assign pin_o = drive_i ? level_i : float_q;
endmodule // dsp_pin_model

// ---- tb_top.sv ----
// self-checking bench of the dual-slope pwm timer
`timescale 1ns/1ps
`include "dsp_timer_consts.svh"
module tb_top;
	logic        clk_i;
	logic        rst_b_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        out_a;
	logic        oe_a;
	logic        out_b;
	logic        oe_b;
	logic        pin_a;
	int          num_errors;
	int          comparisons;

	dsp_timer dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .wave_out_a_o(out_a),
		.wave_out_a_oe_o(oe_a), .wave_out_b_o(out_b), .wave_out_b_oe_o(oe_b));
	dsp_pin_model pin_a_u (.clk_i(clk_i), .drive_i(oe_a), .level_i(out_a), .pin_o(pin_a));

	// 40 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic finish_test();
		$display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// a wait that ran out is a mismatch and ends the run
	task automatic tmo();
		chk(32'h0, 32'h1);
		finish_test();
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) tmo();
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask

	// counter stopped and parked at 1 so a new top never lies below it
	task automatic cfg(input logic [3:0] m, input logic [1:0] act, input logic [15:0] ca,
		input logic [15:0] cap);
		wr(`DSP_OFS_CTRL, {28'h0, m});
		wr(`DSP_OFS_COUNT, 32'h1);
		wr(`DSP_OFS_CAPTURE, {16'h0, cap});
		wr(`DSP_OFS_CMP_A, {16'h0, ca});
		wr(`DSP_OFS_CTRL, {19'h0, 2'h1, 3'h1, 2'h0, act, m});
	endtask

	// high time and period of output a in clocks, from one rising edge
	task automatic meas(output int hi, output int per);
		int n;
		n = 0;
		hi = 0;
		// step off the edge so the output launched there is settled
		#1;
		while (out_a !== 1'b0 && n < 20000) begin @(posedge clk_i); #1; n++; end
		while (out_a !== 1'b1 && n < 20000) begin @(posedge clk_i); #1; n++; end
		while (out_a === 1'b1 && n < 20000) begin @(posedge clk_i); #1; n++; hi++; end
		per = hi;
		while (out_a === 1'b0 && n < 20000) begin @(posedge clk_i); #1; n++; per++; end
		if (n >= 20000) tmo();
	endtask

	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		rd(`DSP_OFS_CTRL, r);
		chk(r, 32'h0);
		rd(`DSP_OFS_STATUS, r);
		chk(r & 32'hF, 32'h0);
		apb(1'b0, 12'h018, 32'h0, r, e);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test regs done");
	endtask

	task automatic t_mask();
		logic [31:0] r;
		wr(`DSP_OFS_CTRL, 32'h1);
		wr(`DSP_OFS_CMP_A, 32'hFFFF);
		rd(`DSP_OFS_CMP_A, r);
		chk(r, 32'h00FF);
		wr(`DSP_OFS_CTRL, 32'h3);
		wr(`DSP_OFS_CMP_B, 32'hFFFF);
		rd(`DSP_OFS_CMP_B, r);
		chk(r, 32'h03FF);
		wr(`DSP_OFS_CTRL, 32'hA);
		wr(`DSP_OFS_CMP_A, 32'hABCD);
		rd(`DSP_OFS_CMP_A, r);
		chk(r, 32'hABCD);
		$display("test mask done");
	endtask

	task automatic t_dir();
		cfg(4'hA, 2'h2, 16'h10, 16'h30);
		wr(`DSP_OFS_CTRL, {19'h0, 2'h0, 3'h1, 2'h2, 2'h2, 4'hA});
		@(posedge clk_i);
		#1;
		chk({30'h0, oe_a, oe_b}, 32'h0);
		wr(`DSP_OFS_CTRL, {19'h0, 2'h3, 3'h1, 2'h2, 2'h2, 4'hA});
		@(posedge clk_i);
		#1;
		chk({30'h0, oe_a, oe_b}, 32'h3);
		$display("test dir done");
	endtask

	// every dual-slope mode: period, duty and flags
	task automatic t_modes();
		logic [3:0]  md[8] = '{4'h1, 4'h2, 4'h3, 4'hA, 4'hA, 4'h8, 4'hB, 4'h9};
		logic [1:0]  ac[8] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h2, 2'h3, 2'h1, 2'h1};
		logic [15:0] ca[8] = '{16'h40, 16'h40, 16'h100, 16'h10, 16'h1, 16'h10, 16'h20, 16'h20};
		logic [15:0] cp[8] = '{16'h0, 16'h0, 16'h0, 16'h30, 16'h3, 16'h30, 16'h0, 16'h0};
		int          eh[8] = '{128, 894, 512, 32, 2, 64, 64, 64};
		int          ep[8] = '{510, 1022, 2046, 96, 6, 96, 128, 128};
		logic [3:0]  fl[8] = '{4'h1, 4'h1, 4'h1, 4'h9, 4'h9, 4'h9, 4'h3, 4'h3};
		logic [31:0] r;
		int          hi;
		int          per;
		for (int i = 0; i < 8; i++) begin
			cfg(md[i], ac[i], ca[i], cp[i]);
			repeat (ep[i]) @(posedge clk_i);
			meas(hi, per);
			chk(per, ep[i]);
			chk(hi, eh[i]);
			chk({30'h0, oe_a, pin_a}, {30'h0, 1'b1, out_a});
			wr(`DSP_OFS_STATUS, 32'hF);
			repeat (ep[i] + 8) @(posedge clk_i);
			rd(`DSP_OFS_STATUS, r);
			chk({28'h0, r[3:0] & fl[i]}, {28'h0, fl[i]});
		end
		$display("test modes done");
	endtask

	// count high clocks of both outputs over a window longer than two periods
	task automatic hold_cnt(output int hi, output int hib);
		hi = 0;
		hib = 0;
		repeat (130) begin
			@(posedge clk_i);
			#1;
			if (out_a === 1'b1) hi++;
			if (out_b === 1'b1) hib++;
		end
	endtask

	// both compare units get the same extreme value and action
	task automatic t_extreme();
		logic [15:0] cv[4] = '{16'h0, 16'h20, 16'h0, 16'h20};
		logic [1:0]  av[4] = '{2'h2, 2'h2, 2'h3, 2'h3};
		int          ev[4] = '{0, 130, 130, 0};
		int          hi;
		int          hib;
		for (int i = 0; i < 4; i++) begin
			cfg(4'hA, av[i], cv[i], 16'h20);
			wr(`DSP_OFS_CMP_B, {16'h0, cv[i]});
			wr(`DSP_OFS_CTRL, {19'h0, 2'h3, 3'h1, av[i], av[i], 4'hA});
			repeat (200) @(posedge clk_i);
			hold_cnt(hi, hib);
			chk(hi, ev[i]);
			chk(hib, ev[i]);
		end
		$display("test extreme done");
	endtask

	// compare above top: no match flag, outputs frozen low from the last extreme case
	task automatic t_above();
		logic [31:0] r;
		int          hi;
		int          hib;
		cfg(4'hA, 2'h2, 16'h30, 16'h20);
		wr(`DSP_OFS_CMP_B, 32'h30);
		wr(`DSP_OFS_CTRL, {19'h0, 2'h3, 3'h1, 2'h2, 2'h2, 4'hA});
		repeat (200) @(posedge clk_i);
		wr(`DSP_OFS_STATUS, 32'hF);
		hold_cnt(hi, hib);
		chk(hi, 32'h0);
		chk(hib, 32'h0);
		rd(`DSP_OFS_STATUS, r);
		chk({29'h0, r[2:0]}, 32'h1);
		$display("test above done");
	endtask

	// prescale factors 8, 64, 256 and 1024 on a 2-bit top: period 2*N*top, high 2*N*compare
	task automatic t_presc();
		logic [2:0] cs[4] = '{3'h2, 3'h3, 3'h4, 3'h5};
		int         nv[4] = '{8, 64, 256, 1024};
		int         hi;
		int         per;
		for (int i = 0; i < 4; i++) begin
			cfg(4'hA, 2'h2, 16'h1, 16'h3);
			wr(`DSP_OFS_CTRL, {19'h0, 2'h1, cs[i], 2'h0, 2'h2, 4'hA});
			repeat (6 * nv[i]) @(posedge clk_i);
			meas(hi, per);
			chk(per, 6 * nv[i]);
			chk(hi, 2 * nv[i]);
		end
		$display("test presc done");
	endtask

	// top moved while running, in frequency mode through buffered compare a
	task automatic t_retop();
		int hi;
		int per;
		cfg(4'h9, 2'h1, 16'h20, 16'h0);
		repeat (300) @(posedge clk_i);
		wr(`DSP_OFS_CMP_A, 32'h10);
		repeat (300) @(posedge clk_i);
		meas(hi, per);
		chk(per, 32'h40);
		chk(hi, 32'h20);
		$display("test retop done");
	endtask

	initial begin
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 12'h000;
		pwdata      = 32'h0;
		rst_b_i     = 1'b0;
		num_errors  = 0;
		comparisons = 0;
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_regs();
		t_mask();
		t_dir();
		t_modes();
		t_extreme();
		t_above();
		t_presc();
		t_retop();
		finish_test();
	end
endmodule // tb_top
